// ---- core/fqrom_pkg.sv ----
package fqrom_pkg;

	// ------------------------------------------------------------------
	// Variant selection
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		FQROM_DEN_512M = 3'b001,
		FQROM_DEN_1G   = 3'b010,
		FQROM_DEN_2G   = 3'b100
	} fqrom_density_t;

	typedef enum logic [2:0] {
		FQROM_LAY_TOP = 3'b001,
		FQROM_LAY_BOT = 3'b010,
		FQROM_LAY_SYM = 3'b100
	} fqrom_layout_t;

	// ------------------------------------------------------------------
	// Query addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] FQROM_ADDR_CORE_MIN   = 8'h1b;
	localparam logic [7:0] FQROM_ADDR_CORE_MAX   = 8'h1c;
	localparam logic [7:0] FQROM_ADDR_PROG_MIN   = 8'h1d;
	localparam logic [7:0] FQROM_ADDR_PROG_MAX   = 8'h1e;
	localparam logic [7:0] FQROM_ADDR_WORD_TYP   = 8'h1f;
	localparam logic [7:0] FQROM_ADDR_BUF_TYP    = 8'h20;
	localparam logic [7:0] FQROM_ADDR_BLK_TYP    = 8'h21;
	localparam logic [7:0] FQROM_ADDR_CHIP_TYP   = 8'h22;
	localparam logic [7:0] FQROM_ADDR_WORD_MAX   = 8'h23;
	localparam logic [7:0] FQROM_ADDR_BUF_MAX    = 8'h24;
	localparam logic [7:0] FQROM_ADDR_BLK_MAX    = 8'h25;
	localparam logic [7:0] FQROM_ADDR_CHIP_MAX   = 8'h26;
	localparam logic [7:0] FQROM_ADDR_SIZE       = 8'h27;
	localparam logic [7:0] FQROM_ADDR_BUSW       = 8'h28;
	localparam logic [7:0] FQROM_ADDR_WBUF       = 8'h2a;
	localparam logic [7:0] FQROM_ADDR_RCOUNT     = 8'h2c;
	localparam logic [7:0] FQROM_ADDR_REG1       = 8'h2d;
	localparam logic [7:0] FQROM_ADDR_REG2       = 8'h31;
	localparam logic [7:0] FQROM_ADDR_RSVD       = 8'h35;
	localparam logic [7:0] FQROM_ADDR_LAST       = 8'h38;

	// ------------------------------------------------------------------
	// Fixed query values
	// ------------------------------------------------------------------
	localparam logic [7:0]  FQROM_VAL_CORE_MIN  = 8'h17;
	localparam logic [7:0]  FQROM_VAL_CORE_MAX  = 8'h20;
	localparam logic [7:0]  FQROM_VAL_PROG_MIN  = 8'h85;
	localparam logic [7:0]  FQROM_VAL_PROG_MAX  = 8'h95;
	localparam logic [7:0]  FQROM_VAL_WORD_TYP  = 8'h09;
	localparam logic [7:0]  FQROM_VAL_BUF_TYP   = 8'h0a;
	localparam logic [7:0]  FQROM_VAL_BLK_TYP   = 8'h0a;
	localparam logic [7:0]  FQROM_VAL_CHIP_TYP  = 8'h00;
	localparam logic [7:0]  FQROM_VAL_WORD_MAX  = 8'h01;
	localparam logic [7:0]  FQROM_VAL_BUF_MAX   = 8'h02;
	localparam logic [7:0]  FQROM_VAL_BLK_MAX   = 8'h02;
	localparam logic [7:0]  FQROM_VAL_CHIP_MAX  = 8'h00;
	localparam logic [7:0]  FQROM_VAL_SIZE_512M = 8'h1a;
	localparam logic [7:0]  FQROM_VAL_SIZE_BIG  = 8'h1b;
	localparam logic [15:0] FQROM_VAL_BUSW      = 16'h0001;
	localparam logic [15:0] FQROM_VAL_WBUF      = 16'h000a;
	localparam logic [7:0]  FQROM_VAL_RCNT_ASYM = 8'h02;
	localparam logic [7:0]  FQROM_VAL_RCNT_SYM  = 8'h01;
	localparam logic [31:0] FQROM_VAL_RSVD      = 32'h0000_0000;
	localparam logic [7:0]  FQROM_VAL_UNMAPPED  = 8'h00;
	localparam logic [7:0]  FQROM_VAL_HIGH_BYTE = 8'h00;

	// Region words: size in 256-byte units above, block count less one below.
	localparam logic [31:0] FQROM_RG_512M_MAIN  = 32'h0200_01fe;
	localparam logic [31:0] FQROM_RG_512M_SYM   = 32'h0200_01ff;
	localparam logic [31:0] FQROM_RG_1G_MAIN    = 32'h0200_03fe;
	localparam logic [31:0] FQROM_RG_1G_SYM     = 32'h0200_03ff;
	localparam logic [31:0] FQROM_RG_PARAM      = 32'h0080_0003;
	localparam logic [31:0] FQROM_RG_NONE       = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       rd;
		logic [7:0] addr;
	} fqrom_req_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} fqrom_rsp_t;

endpackage

// ---- core/fqrom_top.sv ----
`timescale 1ns/1ns
// Function
// - Address 1Bh returns 17h, minimum core supply, BCD volts and tenths.
// - Address 1Ch returns 20h, maximum core supply, same BCD encoding.
// - Addresses 1Dh and 1Eh return 85h and 95h, programming supply range.
// - Address 1Fh returns 09h, typical word program timeout exponent.
// - Address 20h returns 0Ah, typical full buffer write timeout exponent.
// - Address 21h returns 0Ah, typical block erase timeout exponent in ms.
// - Address 22h returns 00h, chip erase not offered.
// - Address 23h returns 01h, maximum word program multiplier exponent.
// - Address 24h returns 02h, maximum buffer write multiplier exponent.
// - Address 25h returns 02h, maximum block erase multiplier exponent.
// - Address 26h returns 00h, maximum chip erase multiplier exponent.
// - Address 27h returns size exponent: 1Ah for 512Mb, 1Bh otherwise.
// - Addresses 28h and 29h return bus width field 01h then 00h.
// - Addresses 2Ah and 2Bh return write buffer exponent 0Ah then 00h.
// - Address 2Ch returns region count: 02h asymmetric, 01h symmetric.
// - Addresses 2Dh to 30h give region one: count less one, size/256.
// - Addresses 31h to 34h give region two in the same layout.
// - Addresses 35h to 38h return the reserved region bytes.
// - Address 2Dh returns FEh top, 03h bottom, FFh symmetric.
// - Each byte is driven on the low data byte, high byte zero.
// - Reserved region bytes 35h to 38h read as 00h in every variant.
module fqrom_top
	import fqrom_pkg::*;
#(
	parameter fqrom_density_t DENSITY = FQROM_DEN_512M,
	parameter fqrom_layout_t  LAYOUT  = FQROM_LAY_SYM
) (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	// Query read request
	input  wire fqrom_req_t req_i,
	// Query read answer
	output fqrom_rsp_t      rsp_o
);

	// ------------------------------------------------------------------
	// Variant constants
	// ------------------------------------------------------------------
	// The variant is fixed at build time, so all of this folds to constants.
	// A 2Gb part exists only symmetric; other layouts fall back to it.
	localparam logic IS_SYM = (LAYOUT == FQROM_LAY_SYM) ||
		(DENSITY == FQROM_DEN_2G);
	localparam logic IS_TOP = !IS_SYM && (LAYOUT == FQROM_LAY_TOP);
	localparam logic IS_512 = (DENSITY == FQROM_DEN_512M);

	localparam logic [7:0] SIZE_EXP = IS_512 ? FQROM_VAL_SIZE_512M :
		FQROM_VAL_SIZE_BIG;
	localparam logic [7:0] REGION_COUNT = IS_SYM ? FQROM_VAL_RCNT_SYM :
		FQROM_VAL_RCNT_ASYM;
	localparam logic [31:0] MAIN_RG = IS_SYM ?
		(IS_512 ? FQROM_RG_512M_SYM : FQROM_RG_1G_SYM) :
		(IS_512 ? FQROM_RG_512M_MAIN : FQROM_RG_1G_MAIN);
	// Top parts list the main blocks first, bottom parts the parameter
	// blocks first, so the low byte at 2Dh tells the layout apart.
	localparam logic [31:0] REGION_ONE = IS_TOP ? MAIN_RG :
		(IS_SYM ? MAIN_RG : FQROM_RG_PARAM);
	localparam logic [31:0] REGION_TWO = IS_SYM ? FQROM_RG_NONE :
		(IS_TOP ? FQROM_RG_PARAM : MAIN_RG);

	// ------------------------------------------------------------------
	// Byte lookup
	// ------------------------------------------------------------------
	logic [7:0] next_byte;
	logic [1:0] rel;
	logic [4:0] shift;

	always_comb begin
		rel = 2'h0;
		shift = 5'h00;
		next_byte = FQROM_VAL_UNMAPPED;
		if (req_i.addr == FQROM_ADDR_CORE_MIN) begin
			next_byte = FQROM_VAL_CORE_MIN;
		end else if (req_i.addr == FQROM_ADDR_CORE_MAX) begin
			next_byte = FQROM_VAL_CORE_MAX;
		end else if (req_i.addr == FQROM_ADDR_PROG_MIN) begin
			next_byte = FQROM_VAL_PROG_MIN;
		end else if (req_i.addr == FQROM_ADDR_PROG_MAX) begin
			next_byte = FQROM_VAL_PROG_MAX;
		end else if (req_i.addr == FQROM_ADDR_WORD_TYP) begin
			next_byte = FQROM_VAL_WORD_TYP;
		end else if (req_i.addr == FQROM_ADDR_BUF_TYP) begin
			next_byte = FQROM_VAL_BUF_TYP;
		end else if (req_i.addr == FQROM_ADDR_BLK_TYP) begin
			next_byte = FQROM_VAL_BLK_TYP;
		end else if (req_i.addr == FQROM_ADDR_CHIP_TYP) begin
			next_byte = FQROM_VAL_CHIP_TYP;
		end else if (req_i.addr == FQROM_ADDR_WORD_MAX) begin
			next_byte = FQROM_VAL_WORD_MAX;
		end else if (req_i.addr == FQROM_ADDR_BUF_MAX) begin
			next_byte = FQROM_VAL_BUF_MAX;
		end else if (req_i.addr == FQROM_ADDR_BLK_MAX) begin
			next_byte = FQROM_VAL_BLK_MAX;
		end else if (req_i.addr == FQROM_ADDR_CHIP_MAX) begin
			next_byte = FQROM_VAL_CHIP_MAX;
		end else if (req_i.addr == FQROM_ADDR_SIZE) begin
			next_byte = SIZE_EXP;
		end else if (req_i.addr == FQROM_ADDR_BUSW) begin
			next_byte = FQROM_VAL_BUSW[7:0];
		end else if (req_i.addr == FQROM_ADDR_BUSW + 8'h01) begin
			next_byte = FQROM_VAL_BUSW[15:8];
		end else if (req_i.addr == FQROM_ADDR_WBUF) begin
			next_byte = FQROM_VAL_WBUF[7:0];
		end else if (req_i.addr == FQROM_ADDR_WBUF + 8'h01) begin
			next_byte = FQROM_VAL_WBUF[15:8];
		end else if (req_i.addr == FQROM_ADDR_RCOUNT) begin
			next_byte = REGION_COUNT;
		end else if (req_i.addr >= FQROM_ADDR_REG1 &&
			req_i.addr < FQROM_ADDR_REG2) begin
			rel = 2'(req_i.addr - FQROM_ADDR_REG1);
			shift = {rel, 3'b000};
			next_byte = 8'(REGION_ONE >> shift);
		end else if (req_i.addr >= FQROM_ADDR_REG2 &&
			req_i.addr < FQROM_ADDR_RSVD) begin
			rel = 2'(req_i.addr - FQROM_ADDR_REG2);
			shift = {rel, 3'b000};
			next_byte = 8'(REGION_TWO >> shift);
		end else if (req_i.addr >= FQROM_ADDR_RSVD &&
			req_i.addr <= FQROM_ADDR_LAST) begin
			rel = 2'(req_i.addr - FQROM_ADDR_RSVD);
			shift = {rel, 3'b000};
			next_byte = 8'(FQROM_VAL_RSVD >> shift);
		end
	end

	// ------------------------------------------------------------------
	// Answer register
	// ------------------------------------------------------------------
	// Each field has its own flop so no variable is written by two
	// processes; the port is only a wiring of the two.
	logic        answer_valid;
	logic [15:0] answer_data;

	// Data holds between reads so a slow host may sample it late.
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			answer_data <= 16'h0000;
		end else if (req_i.rd) begin
			answer_data <= {FQROM_VAL_HIGH_BYTE, next_byte};
		end
	end

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			answer_valid <= 1'b0;
		end else begin
			answer_valid <= req_i.rd;
		end
	end

	assign rsp_o = '{valid: answer_valid, data: answer_data};

endmodule

// ---- bench/fqrom_monitor.sv ----
`timescale 1ns/1ns
module fqrom_monitor
	import fqrom_pkg::*;
#(
	parameter fqrom_density_t DENSITY = FQROM_DEN_512M,
	parameter fqrom_layout_t  LAYOUT  = FQROM_LAY_SYM
) (
	// Watched ports
	input wire logic       clk_i,
	input wire logic       resetn_i,
	input wire fqrom_req_t req_i,
	input wire fqrom_rsp_t rsp_o
);
	// ----------------------------------------
	// Query answers
	// ----------------------------------------
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	localparam bit SYM = LAYOUT == FQROM_LAY_SYM || DENSITY == FQROM_DEN_2G;
	localparam logic [7:0] SZ = DENSITY == FQROM_DEN_512M ? 8'h1a : 8'h1b;
	localparam logic [7:0] RC = SYM ? 8'h01 : 8'h02;
	localparam logic [7:0] LO = SYM ? 8'hff
		: (LAYOUT == FQROM_LAY_TOP ? 8'hfe : 8'h03);
	sequence s_take(logic [7:0] a);
		req_i.rd && req_i.addr == a;
	endsequence
	property p_ans(logic [7:0] a, logic [15:0] v);
		s_take(a) |=> rsp_o.valid && rsp_o.data == v;
	endproperty
	a_core_min: assert property (p_ans(8'h1b, 16'h0017))
		else $error("bad 1b");
	a_word_typ: assert property (p_ans(8'h1f, 16'h0009))
		else $error("bad 1f");
	a_size_exp: assert property (p_ans(8'h27, {8'h00, SZ}))
		else $error("bad 27");
	a_region_cnt: assert property (p_ans(8'h2c, {8'h00, RC}))
		else $error("bad 2c");
	a_region_low: assert property (p_ans(8'h2d, {8'h00, LO}))
		else $error("bad 2d");
	a_rsvd_zero: assert property (p_ans(8'h38, 16'h0000))
		else $error("bad 38");
	a_valid_rise: assert property (req_i.rd |=> rsp_o.valid)
		else $error("no answer");
	a_valid_fall: assert property (!req_i.rd |=> !rsp_o.valid)
		else $error("stray answer");
	a_high_zero: assert property (rsp_o.valid |-> !rsp_o.data[15:8])
		else $error("high byte set");
endmodule

// ---- bench/fqrom_host.sv ----
`timescale 1ns/1ns
module fqrom_host
	import fqrom_pkg::*;
#(
	parameter int N = 7
) (
	// Clock
	input  wire logic       clk_i,
	// Query bus
	output fqrom_req_t      req_o,
	input  wire fqrom_rsp_t rsp_i [N]
);
	// ----------------------------------------
	// Query reads
	// ----------------------------------------
	initial req_o = '0;
	// Strobe stays up so calls run back to back; answer is one cycle on.
	task automatic rd(input logic [7:0] a, output fqrom_rsp_t r [N]);
		req_o.rd = 1'b1;
		req_o.addr = a;
		@(negedge clk_i);
		r = rsp_i;
	endtask
	// Released address lines must not keep the last value.
	task automatic idle();
		req_o.rd = 1'b0;
		req_o.addr = ~req_o.addr;
	endtask
endmodule

// ---- bench/fqrom_top_tb.sv ----
`timescale 1ns/1ns
module fqrom_top_tb
	import fqrom_pkg::*;
;
	// ----------------------------------------
	// Seven variants share one host
	// ----------------------------------------
	localparam int N = 7;
	localparam int DI [N] = '{0, 0, 0, 1, 1, 1, 2};
	localparam int LI [N] = '{0, 1, 2, 0, 1, 2, 2};
	logic       clk_i = 1'b0;
	logic       resetn_i = 1'b0;
	fqrom_req_t req;
	fqrom_rsp_t rsp [N];
	fqrom_rsp_t got [N];
	int         mismatches = 0;
	int         checks_done = 0;
	always #10 clk_i = ~clk_i;
	for (genvar g = 0; g < N; g++) begin : gv
		fqrom_top #(.DENSITY(fqrom_density_t'(3'b001 << DI[g])),
			.LAYOUT(fqrom_layout_t'(3'b001 << LI[g]))) fqrom_top_inst (
			.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req), .rsp_o(rsp[g]));
	end
	fqrom_host #(.N(N)) fqrom_host_inst (
		.clk_i(clk_i), .req_o(req), .rsp_i(rsp));
	function automatic logic [15:0] expv(int d, int l, int a);
		logic [7:0] t [12] = '{8'h17, 8'h20, 8'h85, 8'h95, 8'h09, 8'h0a,
			8'h0a, 8'h00, 8'h01, 8'h02, 8'h02, 8'h00};
		bit sym = l == 2 || d == 2;
		logic [31:0] m = {16'h0200,
			(d == 0 ? 16'h01ff : 16'h03ff) - 16'(!sym)};
		logic [31:0] p = 32'h0080_0003;
		logic [31:0] r1 = (sym || l == 0) ? m : p;
		logic [31:0] r2 = sym ? 32'h0 : (l == 0 ? p : m);
		if (a >= 'h1b && a <= 'h26) return {8'h00, t[a - 'h1b]};
		if (a == 'h27) return d == 0 ? 16'h001a : 16'h001b;
		if (a == 'h28) return 16'h0001;
		if (a == 'h2a) return 16'h000a;
		if (a == 'h2c) return sym ? 16'h0001 : 16'h0002;
		if (a >= 'h2d && a <= 'h30) return {8'h00, r1[8*(a-'h2d) +: 8]};
		if (a >= 'h31 && a <= 'h34) return {8'h00, r2[8*(a-'h31) +: 8]};
		return 16'h0000;
	endfunction
	task automatic check(logic [16:0] seen, logic [16:0] want);
		checks_done++;
		if (seen !== want) begin
			mismatches++;
			$display("Error %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		int a;
		void'($urandom(78));
		repeat (8) @(negedge clk_i);
		resetn_i = 1'b1;
		for (int i = 0; i < N; i++) check(rsp[i], 17'h0);
		for (int k = 0; k < 264; k++) begin
			a = k < 64 ? k : $urandom % 256;
			fqrom_host_inst.rd(a[7:0], got);
			for (int i = 0; i < N; i++) begin
				check(got[i], {1'b1, expv(DI[i], LI[i], a)});
			end
			if (k % 5 == 4) begin
				fqrom_host_inst.idle();
				@(negedge clk_i);
				for (int i = 0; i < N; i++) begin
					check(rsp[i], {1'b0, expv(DI[i], LI[i], a)});
				end
			end
		end
		// A reset in mid-run must clear held data and valid again.
		fqrom_host_inst.idle();
		resetn_i = 1'b0;
		@(negedge clk_i);
		resetn_i = 1'b1;
		for (int i = 0; i < N; i++) check(rsp[i], 17'h0);
		conclude();
	end
	// A hang is cut off well beyond the few hundred cycles of traffic.
	initial begin
		#50000;
		mismatches++;
		conclude();
	end
endmodule
bind fqrom_top fqrom_monitor #(.DENSITY(DENSITY), .LAYOUT(LAYOUT))
	fqrom_monitor_inst (.clk_i(clk_i), .resetn_i(resetn_i),
	.req_i(req_i), .rsp_o(rsp_o));
